// ---- verilog/accel_param_sequencer.sv ----
// Parameter-set sequencer with APB register file, trigger handling and DMA requests
`timescale 1ns/1ps
`default_nettype none
module accel_param_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Compute core
  input wire logic core_done,
  output logic core_start,
  output logic [3:0] core_set_index,
  output logic engine_clk_en,
  output logic engine_rst,
  // Front end
  input wire logic fe_pingpong_side,
  output logic [3:0] mem_access_mask,
  // Host and DMA
  output logic host_irq,
  output logic [15:0] dma_req
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] enable_key;
    logic clock_gate;
    logic [2:0] soft_reset;
    logic [11:0] loop_setting;
    logic [3:0] range_first;
    logic [3:0] range_last;
    logic buf_share;
    logic start_bit;
    logic [15:0] in_dma_bits;
    logic [15:0] done_flags;
    logic [15:0][12:0] pset;
    accel_seq_pkg::seq_state_t state;
    logic [3:0] cur;
    logic [11:0] loop_cnt;
    logic pp_prev;
    logic pp_pend;
    logic irq;
    logic [15:0] dma;
    logic start;
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic clk_en;
    logic eng_rst;
    logic [3:0] mask;
  } seq_regs_t;

  seq_regs_t st_reg;
  seq_regs_t st_next;

  logic side_s;
  logic [12:0] cur_word;
  logic [2:0] cur_mode;
  logic [3:0] cur_src;
  logic cur_irq_en;
  logic cur_dma_en;
  logic [3:0] cur_dst;
  logic active;
  logic setup;
  logic access_fire;
  logic wr_fire;

  pin_sync u_side_sync (
    .clk(clk),
    .rst(rst),
    .pin(fe_pingpong_side),
    .level(side_s)
  );

  assign cur_word = st_reg.pset[st_reg.cur];
  assign cur_mode = cur_word[accel_seq_pkg::PS_MODE_LSB +: 3];
  assign cur_src = cur_word[accel_seq_pkg::PS_SRC_LSB +: 4];
  assign cur_irq_en = cur_word[accel_seq_pkg::PS_IRQ_BIT];
  assign cur_dma_en = cur_word[accel_seq_pkg::PS_DMA_BIT];
  assign cur_dst = cur_word[accel_seq_pkg::PS_DST_LSB +: 4];
  // Engine steps only when keyed on, clocked and out of soft reset
  assign active = (st_reg.enable_key == accel_seq_pkg::KEY_ON) && st_reg.clock_gate
                  && (st_reg.soft_reset == accel_seq_pkg::RST_SOFT);
  assign setup = psel && !penable;
  assign access_fire = psel && penable && st_reg.rdy;
  assign wr_fire = access_fire && pwrite;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] done_set;
    logic go;
    done_set = 16'h0000;
    go = 1'b0;
    st_next = st_reg;
    st_next.irq = 1'b0;
    st_next.dma = 16'h0000;
    st_next.start = 1'b0;
    st_next.rdy = 1'b0;
    st_next.err = 1'b0;
    st_next.pp_prev = side_s;
    if (st_reg.soft_reset != accel_seq_pkg::RST_SOFT) begin
      // Whole engine back to reset; configuration survives for reprogramming
      st_next.state = accel_seq_pkg::S_IDLE;
      st_next.cur = st_reg.range_first;
      st_next.loop_cnt = 12'h000;
      st_next.done_flags = 16'h0000;
      st_next.in_dma_bits = 16'h0000;
      st_next.start_bit = 1'b0;
      st_next.pp_pend = 1'b0;
    end else if (st_reg.enable_key != accel_seq_pkg::KEY_ON) begin
      // Disabled: park so the next enable starts clean
      st_next.state = accel_seq_pkg::S_IDLE;
      st_next.cur = st_reg.range_first;
      st_next.loop_cnt = 12'h000;
      st_next.pp_pend = 1'b0;
    end else if (active) begin
      // With the gate open the sequencer steps; closed, state, index and loop count hold
      case (st_reg.state)
        accel_seq_pkg::S_IDLE: begin
          st_next.cur = st_reg.range_first;
          st_next.loop_cnt = 12'h000;
          st_next.state = accel_seq_pkg::S_WAIT;
        end
        accel_seq_pkg::S_WAIT: begin
          case (cur_mode)
            accel_seq_pkg::MODE_HOST: begin
              go = st_reg.start_bit;
              if (go) begin
                st_next.start_bit = 1'b0;
              end
            end
            accel_seq_pkg::MODE_PINGPONG: begin
              go = st_reg.pp_pend;
              if (go) begin
                st_next.pp_pend = 1'b0;
              end
            end
            accel_seq_pkg::MODE_DMA: begin
              go = st_reg.in_dma_bits[cur_src];
              if (go) begin
                st_next.in_dma_bits[cur_src] = 1'b0;
              end
            end
            default: begin
              go = 1'b1;
            end
          endcase
          if (go) begin
            st_next.start = 1'b1;
            st_next.state = accel_seq_pkg::S_RUN;
          end
        end
        accel_seq_pkg::S_RUN: begin
          if (core_done) begin
            st_next.state = accel_seq_pkg::S_DONE;
          end
        end
        accel_seq_pkg::S_DONE: begin
          // Completion events go out in the same cycle the index moves on
          st_next.irq = cur_irq_en;
          if (cur_dma_en) begin
            st_next.dma[cur_dst] = 1'b1;
          end
          done_set[st_reg.cur] = 1'b1;
          st_next.state = accel_seq_pkg::S_WAIT;
          if (st_reg.loop_setting == accel_seq_pkg::LOOP_OFF) begin
            st_next.cur = st_reg.cur;
          end else if (st_reg.cur == st_reg.range_last) begin
            st_next.cur = st_reg.range_first;
            if (st_reg.loop_setting != accel_seq_pkg::LOOP_INFINITE
                && st_reg.loop_cnt + 12'h001 == st_reg.loop_setting) begin
              st_next.state = accel_seq_pkg::S_HALT;
            end
            st_next.loop_cnt = st_reg.loop_cnt + 12'h001;
          end else begin
            st_next.cur = st_reg.cur + 4'h1;
          end
        end
        default: begin
          st_next.state = accel_seq_pkg::S_HALT;
        end
      endcase
    end
    // A switch seen in the same cycle as a consume stays pending
    if (side_s != st_reg.pp_prev) begin
      st_next.pp_pend = 1'b1;
    end

    // ----------------------------------------
    // APB register access
    // ----------------------------------------
    if (setup) begin
      st_next.rdy = 1'b1;
      st_next.rdata = 32'h0000_0000;
      if (paddr == accel_seq_pkg::OFF_ENABLE_KEY) begin
        st_next.rdata[2:0] = st_reg.enable_key;
      end else if (paddr == accel_seq_pkg::OFF_CLOCK_GATE) begin
        st_next.rdata[0] = st_reg.clock_gate;
      end else if (paddr == accel_seq_pkg::OFF_SOFT_RESET) begin
        st_next.rdata[2:0] = st_reg.soft_reset;
      end else if (paddr == accel_seq_pkg::OFF_LOOP_COUNT) begin
        st_next.rdata[11:0] = st_reg.loop_setting;
      end else if (paddr == accel_seq_pkg::OFF_RANGE_FIRST) begin
        st_next.rdata[3:0] = st_reg.range_first;
      end else if (paddr == accel_seq_pkg::OFF_RANGE_LAST) begin
        st_next.rdata[3:0] = st_reg.range_last;
      end else if (paddr == accel_seq_pkg::OFF_BUF_SHARE) begin
        st_next.rdata[0] = st_reg.buf_share;
      end else if (paddr == accel_seq_pkg::OFF_HOST_START) begin
        st_next.rdata[0] = st_reg.start_bit;
      end else if (paddr == accel_seq_pkg::OFF_IN_DMA_BITS) begin
        st_next.rdata[15:0] = st_reg.in_dma_bits;
      end else if (paddr == accel_seq_pkg::OFF_DONE_FLAGS) begin
        st_next.rdata[15:0] = st_reg.done_flags;
      end else if (paddr == accel_seq_pkg::OFF_DONE_CLEAR || paddr == accel_seq_pkg::OFF_DMA_KICK) begin
        st_next.rdata = 32'h0000_0000;
      end else if (paddr == accel_seq_pkg::OFF_STATUS) begin
        st_next.rdata[accel_seq_pkg::ST_CUR_LSB +: 4] = st_reg.cur;
        st_next.rdata[accel_seq_pkg::ST_LOOP_LSB +: 12] = st_reg.loop_cnt;
        st_next.rdata[accel_seq_pkg::ST_STATE_LSB +: 3] = st_reg.state;
      end else if (paddr >= accel_seq_pkg::OFF_PSET_BASE && paddr <= accel_seq_pkg::OFF_PSET_LAST
                   && paddr[1:0] == 2'b00) begin
        st_next.rdata[12:0] = st_reg.pset[paddr[5:2]];
      end else begin
        st_next.err = 1'b1;
      end
    end
    if (wr_fire && !st_reg.err) begin
      if (paddr == accel_seq_pkg::OFF_ENABLE_KEY) begin
        st_next.enable_key = pwdata[2:0];
      end else if (paddr == accel_seq_pkg::OFF_CLOCK_GATE) begin
        st_next.clock_gate = pwdata[0];
      end else if (paddr == accel_seq_pkg::OFF_SOFT_RESET) begin
        st_next.soft_reset = pwdata[2:0];
      end else if (paddr == accel_seq_pkg::OFF_LOOP_COUNT) begin
        st_next.loop_setting = pwdata[11:0];
      end else if (paddr == accel_seq_pkg::OFF_RANGE_FIRST) begin
        st_next.range_first = pwdata[3:0];
      end else if (paddr == accel_seq_pkg::OFF_RANGE_LAST) begin
        st_next.range_last = pwdata[3:0];
      end else if (paddr == accel_seq_pkg::OFF_BUF_SHARE) begin
        st_next.buf_share = pwdata[0];
      end else if (paddr == accel_seq_pkg::OFF_HOST_START) begin
        if (pwdata[0]) begin
          st_next.start_bit = 1'b1;
        end
      end else if (paddr == accel_seq_pkg::OFF_IN_DMA_BITS) begin
        // One-hot signatures accumulate; a consume never eats a fresh set
        st_next.in_dma_bits = st_next.in_dma_bits | pwdata[15:0];
      end else if (paddr == accel_seq_pkg::OFF_DONE_CLEAR) begin
        st_next.done_flags = st_next.done_flags & ~pwdata[15:0];
      end else if (paddr == accel_seq_pkg::OFF_DMA_KICK) begin
        st_next.dma = st_next.dma | pwdata[15:0];
      end else if (paddr >= accel_seq_pkg::OFF_PSET_BASE) begin
        st_next.pset[paddr[5:2]] = pwdata[12:0];
      end
    end
    // Hardware set beats a same-cycle clear
    st_next.done_flags = st_next.done_flags | done_set;

    st_next.clk_en = st_next.clock_gate;
    // Follows the registered controls so a key-off cycle always shows reset next cycle
    st_next.eng_rst = (st_reg.soft_reset != accel_seq_pkg::RST_SOFT)
                      || (st_reg.enable_key != accel_seq_pkg::KEY_ON);
    if (st_reg.buf_share) begin
      // Side high means the front end fills memory one
      st_next.mask = {2'b11, !side_s, side_s};
    end else begin
      st_next.mask = 4'hF;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.eng_rst <= 1'b1;
      st_reg.mask <= 4'hF;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = st_reg.rdata;
  assign pready = st_reg.rdy;
  assign pslverr = st_reg.err;
  assign core_start = st_reg.start;
  assign core_set_index = st_reg.cur;
  assign engine_clk_en = st_reg.clk_en;
  assign engine_rst = st_reg.eng_rst;
  assign mem_access_mask = st_reg.mask;
  assign host_irq = st_reg.irq;
  assign dma_req = st_reg.dma;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic done_step;
  logic kick_fire;
  assign done_step = active && st_reg.state == accel_seq_pkg::S_DONE;
  assign kick_fire = wr_fire && !st_reg.err && paddr == accel_seq_pkg::OFF_DMA_KICK;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_set_end;
    active && st_reg.state == accel_seq_pkg::S_RUN && core_done ##1 done_step;
  endsequence

  property p_set_end_advance;
    s_set_end |=> st_reg.state != accel_seq_pkg::S_DONE && st_reg.state != accel_seq_pkg::S_RUN;
  endproperty
  a_set_end_advance: assert property (p_set_end_advance) else $error("set end did not advance");

  property p_irq_follows_enable;
    done_step |=> host_irq == $past(cur_irq_en) ##1 !host_irq;
  endproperty
  a_irq_follows_enable: assert property (p_irq_follows_enable) else $error("interrupt mismatch");

  property p_dma_on_dest;
    done_step && cur_dma_en |=> dma_req[$past(cur_dst)];
  endproperty
  a_dma_on_dest: assert property (p_dma_on_dest) else $error("DMA trigger missing on channel");

  property p_kick_pulse;
    kick_fire |=> ((dma_req & $past(pwdata[15:0])) == $past(pwdata[15:0]));
  endproperty
  a_kick_pulse: assert property (p_kick_pulse) else $error("host kick did not pulse");

  property p_key_off_parks;
    st_reg.enable_key != accel_seq_pkg::KEY_ON |=> st_reg.state == accel_seq_pkg::S_IDLE
      && st_reg.loop_cnt == 12'h000 && engine_rst;
  endproperty
  a_key_off_parks: assert property (p_key_off_parks) else $error("engine not parked when keyed off");

  property p_gate_freezes;
    st_reg.enable_key == accel_seq_pkg::KEY_ON && !st_reg.clock_gate && st_reg.soft_reset == 3'b000
      |=> st_reg.state == $past(st_reg.state) && st_reg.cur == $past(st_reg.cur);
  endproperty
  a_gate_freezes: assert property (p_gate_freezes) else $error("sequencer moved with clock gated");

  property p_soft_reset;
    st_reg.soft_reset != 3'b000 |=> st_reg.state == accel_seq_pkg::S_IDLE && st_reg.done_flags == 16'h0000;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset ignored");

  property p_infinite_never_halts;
    st_reg.loop_setting == accel_seq_pkg::LOOP_INFINITE && st_reg.state != accel_seq_pkg::S_HALT
      |=> st_reg.state != accel_seq_pkg::S_HALT;
  endproperty
  a_infinite_never_halts: assert property (p_infinite_never_halts) else $error("infinite loop halted");

  property p_zero_loops_hold;
    done_step && st_reg.loop_setting == accel_seq_pkg::LOOP_OFF |=> st_reg.cur == $past(st_reg.cur);
  endproperty
  a_zero_loops_hold: assert property (p_zero_loops_hold) else $error("index moved with looping off");

  property p_wrap_to_first;
    done_step && st_reg.cur == st_reg.range_last && st_reg.loop_setting != accel_seq_pkg::LOOP_OFF
      |=> st_reg.cur == $past(st_reg.range_first);
  endproperty
  a_wrap_to_first: assert property (p_wrap_to_first) else $error("no wrap after last set");

  property p_host_wait;
    active && st_reg.state == accel_seq_pkg::S_WAIT && cur_mode == accel_seq_pkg::MODE_HOST && !st_reg.start_bit
      |=> st_reg.state == accel_seq_pkg::S_WAIT && !core_start;
  endproperty
  a_host_wait: assert property (p_host_wait) else $error("started without host bit");

  property p_dma_wait;
    active && st_reg.state == accel_seq_pkg::S_WAIT && cur_mode == accel_seq_pkg::MODE_DMA
      && !st_reg.in_dma_bits[cur_src] |=> st_reg.state == accel_seq_pkg::S_WAIT;
  endproperty
  a_dma_wait: assert property (p_dma_wait) else $error("started without DMA bit");

  property p_done_sticky;
    (|($past(st_reg.done_flags) & ~st_reg.done_flags)) |-> $past(wr_fire) || ($past(st_reg.soft_reset) != 3'b000);
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag cleared itself");

  property p_share_mask;
    st_reg.buf_share |=> mem_access_mask[1:0] == {!$past(side_s), $past(side_s)};
  endproperty
  a_share_mask: assert property (p_share_mask) else $error("shared buffer access wrong");

endmodule : accel_param_sequencer
`default_nettype wire

// ---- shared/accel_seq_pkg.sv ----
// Constants, register map and types of the accelerator parameter-set sequencer
// Function
// - When a set's computation finishes, issue its completion events, then advance
// - Interrupt the host at set end only if that set's interrupt enable is 1
// - Send a DMA trigger at set end only if that set's DMA enable is 1
// - The set's 4-bit destination field picks one of 16 DMA request lines
// - A host write to the DMA kick register triggers the chosen channels likewise
// - Engine runs only while the 3-bit enable key holds 111b
// - Clock-gate bit 0 stops the engine clock, 1 supplies it
// - Any nonzero soft-reset value returns the whole engine to its reset state
// - Every disabled-to-enabled transition starts from a known reset state
// - The 12-bit loop count sets passes through the set range, up to 4094
// - Loop count all ones loops forever; only a host reset stops it
// - Loop count zero disables automatic sequencing; the host drives each run; here the index holds and the set reruns on its own start condition
// - Start at the first index, run sets in turn, wrap after the last
// - With sharing set, accelerator sees only the ADC buffer not being written
// - With sharing clear, all four local memories are open to the accelerator
// - Start condition field: 000 immediate, 001 host bit, 010 ping-pong, 011 DMA bit
// - DMA mode waits for the incoming trigger bit chosen by the set's source field
// - Host start bit self-clears; the sequencer waits while it is zero
// - Sixteen sticky done flags, cleared one by one through a clear register
package accel_seq_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NSETS = 16;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_ENABLE_KEY = 8'h00;
  localparam logic [7:0] OFF_CLOCK_GATE = 8'h04;
  localparam logic [7:0] OFF_SOFT_RESET = 8'h08;
  localparam logic [7:0] OFF_LOOP_COUNT = 8'h0C;
  localparam logic [7:0] OFF_RANGE_FIRST = 8'h10;
  localparam logic [7:0] OFF_RANGE_LAST = 8'h14;
  localparam logic [7:0] OFF_BUF_SHARE = 8'h18;
  localparam logic [7:0] OFF_HOST_START = 8'h1C;
  localparam logic [7:0] OFF_IN_DMA_BITS = 8'h20;
  localparam logic [7:0] OFF_DONE_FLAGS = 8'h24;
  localparam logic [7:0] OFF_DONE_CLEAR = 8'h28;
  localparam logic [7:0] OFF_DMA_KICK = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_PSET_BASE = 8'h40;
  localparam logic [7:0] OFF_PSET_LAST = 8'h7C;

  // ----------------------------------------
  // Values and reset values
  // ----------------------------------------
  localparam logic [2:0] KEY_ON = 3'b111;
  localparam logic [2:0] RST_KEY = 3'b000;
  localparam logic [2:0] RST_SOFT = 3'b000;
  localparam logic RST_GATE = 1'b0;
  localparam logic [11:0] LOOP_OFF = 12'h000;
  localparam logic [11:0] LOOP_INFINITE = 12'hFFF;
  localparam logic [11:0] RST_LOOPS = 12'h000;

  // ----------------------------------------
  // Parameter-set word layout
  // ----------------------------------------
  localparam int unsigned PS_W = 13;
  localparam int unsigned PS_MODE_LSB = 0;
  localparam int unsigned PS_SRC_LSB = 3;
  localparam int unsigned PS_IRQ_BIT = 7;
  localparam int unsigned PS_DMA_BIT = 8;
  localparam int unsigned PS_DST_LSB = 9;

  // Start conditions
  localparam logic [2:0] MODE_IMMEDIATE = 3'b000;
  localparam logic [2:0] MODE_HOST = 3'b001;
  localparam logic [2:0] MODE_PINGPONG = 3'b010;
  localparam logic [2:0] MODE_DMA = 3'b011;

  // Status word layout
  localparam int unsigned ST_CUR_LSB = 0;
  localparam int unsigned ST_LOOP_LSB = 4;
  localparam int unsigned ST_STATE_LSB = 16;

  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_RUN, S_DONE, S_HALT} seq_state_t;

endpackage : accel_seq_pkg

// ---- verilog/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin in, filtered level out
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // s1 feeds only s2; the level moves once s2 and s3 agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.q;

endmodule : pin_sync
`default_nettype wire

// ---- test/core_model.sv ----
// Behavioural compute core answering each start after a settable delay
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Handshake with the sequencer
  input wire logic core_start,
  input wire logic [7:0] delay,
  output logic core_done
);
  logic busy;
  logic [7:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      core_done <= 1'b0;
    end else begin
      core_done <= 1'b0;
      if (core_start) begin
        busy <= 1'b1;
        cnt <= delay;
      end else if (busy) begin
        if (cnt == 8'h00) begin
          busy <= 1'b0;
          core_done <= 1'b1;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule : core_model
`default_nettype wire

// ---- test/accel_param_sequencer_tb.sv ----
// Self-checking testbench for the parameter-set sequencer
`timescale 1ns/1ps
`default_nettype none
module accel_param_sequencer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fe_side = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] core_delay = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, core_done, core_start, engine_clk_en, engine_rst, host_irq, err;
  logic [3:0] core_set_index, mem_access_mask, dst;
  logic [15:0] dma_req, kick;
  logic [16:0] exp_q[$];
  int bad_count = 0;
  int check_count = 0;

  always #2.5 clk = ~clk;

  accel_param_sequencer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_done(core_done), .core_start(core_start), .core_set_index(core_set_index),
    .engine_clk_en(engine_clk_en), .engine_rst(engine_rst), .fe_pingpong_side(fe_side),
    .mem_access_mask(mem_access_mask), .host_irq(host_irq), .dma_req(dma_req));
  core_model core (.clk(clk), .rst(rst), .core_start(core_start), .delay(core_delay), .core_done(core_done));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rd, e);
  endtask : rdchk

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("queue_left", exp_q.size(), 0);
  endtask : drain

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Every pulse must match the oldest expected event; a wider pulse pops twice
  always @(posedge clk) begin
    if (!rst && (host_irq !== 1'b0 || dma_req !== 16'h0000)) begin
      if (exp_q.size() == 0) begin
        chk("unexpected_event", {host_irq, dma_req}, 0);
      end else begin
        chk("event", {host_irq, dma_req}, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h00c9));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk("enable_key", accel_seq_pkg::OFF_ENABLE_KEY, 0);
    apb(1'b0, 8'hFC, 0);
    chk("unmapped_err", {31'h0, err}, 1);
    apb(1'b1, accel_seq_pkg::OFF_SOFT_RESET, 7);
    apb(1'b1, accel_seq_pkg::OFF_SOFT_RESET, 0);
    apb(1'b1, accel_seq_pkg::OFF_CLOCK_GATE, 1);
    repeat (3) @(posedge clk);
    chk("clk_en", {31'h0, engine_clk_en}, 1);
    apb(1'b1, accel_seq_pkg::OFF_LOOP_COUNT, 32'hFFFF_F001);
    rdchk("loop_count", accel_seq_pkg::OFF_LOOP_COUNT, 1);
    $display("test registers done");
    dst = 4'($urandom_range(15, 0));
    core_delay <= 8'($urandom_range(20, 1));
    apb(1'b1, accel_seq_pkg::OFF_PSET_BASE, {19'h0, dst, 2'b11, 4'h0, accel_seq_pkg::MODE_IMMEDIATE});
    apb(1'b1, accel_seq_pkg::OFF_PSET_BASE + 8'h04, {19'h0, 4'hF, 2'b10, 4'h0, accel_seq_pkg::MODE_HOST});
    apb(1'b1, accel_seq_pkg::OFF_RANGE_FIRST, 0);
    apb(1'b1, accel_seq_pkg::OFF_RANGE_LAST, 1);
    apb(1'b1, accel_seq_pkg::OFF_ENABLE_KEY, 6);
    repeat (40) @(posedge clk);
    chk("engine_rst_key6", {31'h0, engine_rst}, 1);
    exp_q.push_back({1'b1, 16'h0001 << dst});
    exp_q.push_back({1'b0, 16'h8000});
    apb(1'b1, accel_seq_pkg::OFF_ENABLE_KEY, 7);
    repeat (40) @(posedge clk);
    chk("waits_host_bit", exp_q.size(), 1);
    apb(1'b1, accel_seq_pkg::OFF_HOST_START, 1);
    drain();
    rdchk("done_flags", accel_seq_pkg::OFF_DONE_FLAGS, 3);
    apb(1'b0, accel_seq_pkg::OFF_STATUS, 0);
    chk("halt_state", rd[accel_seq_pkg::ST_STATE_LSB +: 3], 4);
    apb(1'b1, accel_seq_pkg::OFF_DONE_CLEAR, 1);
    rdchk("done_cleared", accel_seq_pkg::OFF_DONE_FLAGS, 2);
    $display("test sequencing done");
    kick = 16'($urandom_range(16'hFFFF, 1));
    exp_q.push_back({1'b0, kick});
    apb(1'b1, accel_seq_pkg::OFF_DMA_KICK, {16'h0, kick});
    drain();
    apb(1'b1, accel_seq_pkg::OFF_ENABLE_KEY, 0);
    apb(1'b1, accel_seq_pkg::OFF_SOFT_RESET, 7);
    rdchk("done_after_reset", accel_seq_pkg::OFF_DONE_FLAGS, 0);
    apb(1'b1, accel_seq_pkg::OFF_SOFT_RESET, 0);
    $display("test kick and reset done");
    apb(1'b1, accel_seq_pkg::OFF_PSET_BASE + 8'h08, {19'h0, 4'h0, 2'b01, 4'h0, accel_seq_pkg::MODE_HOST});
    apb(1'b1, accel_seq_pkg::OFF_RANGE_FIRST, 2);
    apb(1'b1, accel_seq_pkg::OFF_RANGE_LAST, 2);
    apb(1'b1, accel_seq_pkg::OFF_LOOP_COUNT, 32'h0000_0FFF);
    apb(1'b1, accel_seq_pkg::OFF_ENABLE_KEY, 7);
    repeat (2) begin
      exp_q.push_back({1'b1, 16'h0000});
      apb(1'b1, accel_seq_pkg::OFF_HOST_START, 1);
      drain();
    end
    apb(1'b0, accel_seq_pkg::OFF_STATUS, 0);
    chk("infinite_status", rd[18:0], {3'd1, 12'd2, 4'd2});
    chk("set_index", core_set_index, 2);
    apb(1'b1, accel_seq_pkg::OFF_CLOCK_GATE, 0);
    apb(1'b1, accel_seq_pkg::OFF_HOST_START, 1);
    repeat (30) @(posedge clk);
    chk("gated_clk_en", {31'h0, engine_clk_en}, 0);
    exp_q.push_back({1'b1, 16'h0000});
    apb(1'b1, accel_seq_pkg::OFF_CLOCK_GATE, 1);
    drain();
    $display("test looping and gating done");
    apb(1'b1, accel_seq_pkg::OFF_BUF_SHARE, 1);
    fe_side <= 1'b1;
    repeat (8) @(posedge clk);
    chk("mask_side1", mem_access_mask, 4'b1101);
    fe_side <= 1'b0;
    repeat (8) @(posedge clk);
    chk("mask_side0", mem_access_mask, 4'b1110);
    apb(1'b1, accel_seq_pkg::OFF_BUF_SHARE, 0);
    repeat (3) @(posedge clk);
    chk("mask_all", mem_access_mask, 4'b1111);
    $display("test memories done");
    print_verdict();
  end
endmodule : accel_param_sequencer_tb
`default_nettype wire
